// ===== rrs_exec_monitor.sv
// checker for the return, rotate and subtract execution unit
`timescale 1ns/1ps
module rrs_exec_monitor
  import rrs_pkg::*;
#(
  parameter int PC_WIDTH    = 11,
  parameter int STACK_DEPTH = 8
) (
  input wire logic                clk,
  input wire logic                rst_n,
  input wire logic                op_valid,
  input wire rrs_pkg::rrs_op_t    op_code,
  input wire logic [6:0]          op_reg_addr,
  input wire logic                op_to_reg,
  input wire logic [7:0]          op_imm,
  input wire logic [4:0]          op_sfr_idx,
  input wire logic                op_ready,
  input wire logic                call_push,
  input wire logic [PC_WIDTH-1:0] call_push_addr,
  input wire logic [7:0]          reg_addr,
  input wire logic [7:0]          reg_wdata,
  input wire logic                reg_wr,
  input wire logic                reg_rd,
  input wire logic [7:0]          reg_rdata,
  input wire logic [7:0]          work_q,
  input wire logic                carry_q,
  input wire logic                nibble_q,
  input wire logic                zero_q,
  input wire logic [PC_WIDTH-1:0] pc_q
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  logic       take;
  logic [2:0] flags;
  logic [8:0] imm_sum;
  logic [4:0] imm_nib;
  // a bus write in the same cycle could legally move flags, so skip those
  assign take    = op_valid && op_ready && !reg_wr;
  assign flags   = {zero_q, nibble_q, carry_q};
  assign imm_sum = {1'b0, op_imm} + {1'b0, ~work_q} + {8'h00, carry_q};
  assign imm_nib = {1'b0, op_imm[3:0]} + {1'b0, ~work_q[3:0]} + {4'h0, carry_q};
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  a_ret_two_cycles: assert property (take && op_code == OP_CALL_EXIT
    |=> !op_ready ##1 op_ready) else $error("return length wrong");
  a_ret_flags_kept: assert property (take && op_code == OP_CALL_EXIT
    |=> $stable(flags)) else $error("return moved a flag");
  a_rot_keeps_zn: assert property (take && op_code == OP_ROT_RIGHT
    |=> $stable({zero_q, nibble_q})) else $error("rotate moved zero or nibble");
  a_imm_result: assert property (take && op_code == OP_SUB_BOR_IMM
    |=> {carry_q, work_q} == $past(imm_sum)) else $error("immediate subtract wrong");
  a_imm_nibble: assert property (take && op_code == OP_SUB_BOR_IMM
    |=> nibble_q == $past(imm_nib[4])) else $error("nibble carry wrong");
  a_sub_zero_flag: assert property (take && op_code inside {OP_SUB_BOR_REG,
    OP_REG_MINUS} && !op_to_reg |=> zero_q == (work_q == 8'h00)) else $error("zero flag wrong");
  a_file_target: assert property (take && op_to_reg && op_code inside {OP_ROT_RIGHT,
    OP_SUB_BOR_REG, OP_REG_MINUS} |=> $stable(work_q)) else $error("file target hit work");
  a_sfr_flags_kept: assert property (take && op_code inside {OP_SFR_WRITE,
    OP_SFR_READ} |=> $stable(flags)) else $error("s-page move moved a flag");
  a_read_one_cycle: assert property (reg_rd && reg_addr == ADDR_WORK
    |=> reg_rdata == $past(work_q)) else $error("work read wrong");
  // main scenarios
  c_ret: cover property (take && op_code == OP_CALL_EXIT);
  c_imm: cover property (take && op_code == OP_SUB_BOR_IMM);
  c_rot: cover property (take && op_code == OP_ROT_RIGHT && op_to_reg);
endmodule

// ===== rrs_exec_unit.sv
// execution unit for return, rotate right, subtracts and s-page moves
`timescale 1ns/1ps
module rrs_exec_unit
  import rrs_pkg::*;
#(
  parameter int PC_WIDTH    = 11,
  parameter int STACK_DEPTH = 8
) (
  clk,
  rst_n,
  op_valid,
  op_code,
  op_reg_addr,
  op_to_reg,
  op_imm,
  op_sfr_idx,
  op_ready,
  call_push,
  call_push_addr,
  reg_addr,
  reg_wdata,
  reg_wr,
  reg_rd,
  reg_rdata,
  work_q,
  carry_q,
  nibble_q,
  zero_q,
  pc_q
);
  localparam int SPW = $clog2(STACK_DEPTH);

  input  wire logic                clk;
  input  wire logic                rst_n;
  input  wire logic                op_valid;
  input  wire rrs_pkg::rrs_op_t    op_code;
  input  wire logic [6:0]          op_reg_addr;
  input  wire logic                op_to_reg;
  input  wire logic [7:0]          op_imm;
  input  wire logic [4:0]          op_sfr_idx;
  output logic                     op_ready;
  input  wire logic                call_push;
  input  wire logic [PC_WIDTH-1:0] call_push_addr;
  input  wire logic [7:0]          reg_addr;
  input  wire logic [7:0]          reg_wdata;
  input  wire logic                reg_wr;
  input  wire logic                reg_rd;
  output logic      [7:0]          reg_rdata;
  output logic      [7:0]          work_q;
  output logic                     carry_q;
  output logic                     nibble_q;
  output logic                     zero_q;
  output logic      [PC_WIDTH-1:0] pc_q;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [7:0]          file_mem  [FILE_DEPTH];
  logic [7:0]          sfr_ff    [SFR_COUNT];
  logic [PC_WIDTH-1:0] stack_mem [STACK_DEPTH];

  rrs_state_t          state_ff,  nxt_state;
  logic [7:0]          work_ff,   nxt_work;
  logic                carry_ff,  nxt_carry;
  logic                nibble_ff, nxt_nibble;
  logic                zero_ff,   nxt_zero;
  logic [PC_WIDTH-1:0] pc_ff,     nxt_pc;
  logic [SPW-1:0]      sp_ff,     nxt_sp;
  logic [7:0]          rdata_ff,  nxt_rdata;

  logic                accept;
  logic [7:0]          file_rd;
  logic [7:0]          sub_a;
  logic                sub_cin;
  logic [7:0]          sub_diff;
  logic                sub_carry;
  logic                sub_nibble;
  logic                sub_zero;
  logic [7:0]          result;
  logic                file_we;
  logic [6:0]          file_waddr;
  logic [7:0]          file_wdata;
  logic                sfr_we;
  logic [4:0]          sfr_widx;
  logic [7:0]          sfr_wdata;
  logic                stack_we;
  logic [7:0]          sfr_bus_idx;

  // ----------------------------------------------------------------
  // operand selection and subtractor
  // ----------------------------------------------------------------
  assign accept   = op_valid && (state_ff == ST_RUN);
  assign op_ready = (state_ff == ST_RUN); // low during the second return cycle
  assign file_rd  = file_mem[op_reg_addr];

  // reg_minus uses a fixed carry-in of one; borrow ops feed the carry flag
  always_comb begin
    sub_a   = (op_code == OP_SUB_BOR_IMM) ? op_imm : file_rd;
    sub_cin = (op_code == OP_REG_MINUS) ? 1'b1 : carry_ff;
  end

  rrs_sub_unit u_sub (
    .a          (sub_a),
    .b          (work_ff),
    .cin        (sub_cin),
    .diff       (sub_diff),
    .carry_out  (sub_carry),
    .nibble_out (sub_nibble),
    .zero_out   (sub_zero)
  );

  // ----------------------------------------------------------------
  // instruction execution: next state of core registers
  // ----------------------------------------------------------------
  // bus writes are applied first so a same-cycle instruction wins over them
  always_comb begin
    nxt_state  = state_ff;
    nxt_work   = work_ff;
    nxt_carry  = carry_ff;
    nxt_nibble = nibble_ff;
    nxt_zero   = zero_ff;
    nxt_pc     = pc_ff;
    nxt_sp     = sp_ff;
    result     = 8'h00;
    file_we    = 1'b0;
    file_waddr = reg_addr[6:0];
    file_wdata = reg_wdata;
    sfr_we     = 1'b0;
    sfr_widx   = 5'h00;
    sfr_wdata  = reg_wdata;
    stack_we   = 1'b0;
    sfr_bus_idx = reg_addr - ADDR_SFR_BASE;
    if (reg_wr) begin
      if (reg_addr <= ADDR_FILE_LAST) begin
        file_we = 1'b1;
      end else if (reg_addr == ADDR_WORK) begin
        nxt_work = reg_wdata;
      end else if (reg_addr == ADDR_STATUS) begin
        nxt_carry  = reg_wdata[STAT_CARRY_BIT];
        nxt_nibble = reg_wdata[STAT_NIBBLE_BIT];
        nxt_zero   = reg_wdata[STAT_ZERO_BIT];
      end else if (reg_addr >= ADDR_SFR_BASE && reg_addr <= ADDR_SFR_LAST) begin
        sfr_we   = 1'b1;
        sfr_widx = sfr_bus_idx[4:0];
      end
    end
    case (state_ff)
      ST_RUN: begin
        if (accept) begin
          nxt_pc = pc_ff + {{(PC_WIDTH-1){1'b0}}, 1'b1};
          case (op_code)
            OP_CALL_EXIT: begin
              nxt_pc    = stack_mem[sp_ff - {{(SPW-1){1'b0}}, 1'b1}];
              nxt_sp    = sp_ff - {{(SPW-1){1'b0}}, 1'b1};
              nxt_state = ST_RET_WAIT;
            end
            OP_ROT_RIGHT: begin
              result    = {carry_ff, file_rd[7:1]};
              nxt_carry = file_rd[0];
            end
            OP_SUB_BOR_REG, OP_REG_MINUS: begin
              result     = sub_diff;
              nxt_carry  = sub_carry;
              nxt_nibble = sub_nibble;
              nxt_zero   = sub_zero;
            end
            OP_SUB_BOR_IMM: begin
              nxt_work   = sub_diff;
              nxt_carry  = sub_carry;
              nxt_nibble = sub_nibble;
              nxt_zero   = sub_zero;
            end
            OP_SFR_WRITE: begin
              if (op_sfr_idx < 5'(SFR_COUNT)) begin
                sfr_we    = 1'b1;
                sfr_widx  = op_sfr_idx;
                sfr_wdata = work_ff;
              end
            end
            OP_SFR_READ: begin
              if (op_sfr_idx < 5'(SFR_COUNT)) begin
                nxt_work = sfr_ff[op_sfr_idx];
              end else begin
                nxt_work = 8'h00;
              end
            end
            default: begin
            end
          endcase
          // destination steering for file operand instructions
          if (op_code == OP_ROT_RIGHT || op_code == OP_SUB_BOR_REG ||
              op_code == OP_REG_MINUS) begin
            if (op_to_reg) begin
              file_we    = 1'b1;
              file_waddr = op_reg_addr;
              file_wdata = result;
            end else begin
              nxt_work = result;
            end
          end
        end
        // a push is dropped in a cycle that also pops
        if (call_push && !(accept && op_code == OP_CALL_EXIT)) begin
          stack_we = 1'b1;
          nxt_sp   = sp_ff + {{(SPW-1){1'b0}}, 1'b1};
        end
      end
      ST_RET_WAIT: begin
        nxt_state = ST_RUN;
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // core registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff  <= ST_RUN;
      work_ff   <= WORK_RESET;
      carry_ff  <= FLAG_RESET;
      nibble_ff <= FLAG_RESET;
      zero_ff   <= FLAG_RESET;
      pc_ff     <= '0;
      sp_ff     <= '0;
    end else begin
      state_ff  <= nxt_state;
      work_ff   <= nxt_work;
      carry_ff  <= nxt_carry;
      nibble_ff <= nxt_nibble;
      zero_ff   <= nxt_zero;
      pc_ff     <= nxt_pc;
      sp_ff     <= nxt_sp;
    end
  end

  // data file and stack hold data only, so they carry no reset
  always_ff @(posedge clk) begin
    if (file_we) begin
      file_mem[file_waddr] <= file_wdata;
    end
    if (stack_we) begin
      stack_mem[sp_ff] <= call_push_addr; // pointer wraps when full
    end
  end

  // s-page registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < SFR_COUNT; i++) begin
        sfr_ff[i] <= SFR_RESET;
      end
    end else if (sfr_we) begin
      sfr_ff[sfr_widx] <= sfr_wdata;
    end
  end

  // ----------------------------------------------------------------
  // register port read path
  // ----------------------------------------------------------------
  // data is valid only in the cycle after the read strobe
  always_comb begin
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      if (reg_addr <= ADDR_FILE_LAST) begin
        nxt_rdata = file_mem[reg_addr[6:0]];
      end else if (reg_addr == ADDR_WORK) begin
        nxt_rdata = work_ff;
      end else if (reg_addr == ADDR_STATUS) begin
        nxt_rdata = {5'h00, zero_ff, nibble_ff, carry_ff};
      end else if (reg_addr == ADDR_PC_LO) begin
        nxt_rdata = 8'(pc_ff);
      end else if (reg_addr == ADDR_PC_HI) begin
        nxt_rdata = 8'(pc_ff >> 8);
      end else if (reg_addr == ADDR_SP) begin
        nxt_rdata = 8'(sp_ff);
      end else if (reg_addr >= ADDR_SFR_BASE && reg_addr <= ADDR_SFR_LAST) begin
        nxt_rdata = sfr_ff[sfr_bus_idx[4:0]];
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_ff <= 8'h00;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign work_q    = work_ff;
  assign carry_q   = carry_ff;
  assign nibble_q  = nibble_ff;
  assign zero_q    = zero_ff;
  assign pc_q      = pc_ff;
endmodule

// ===== rrs_pkg.sv
// constants, opcodes and register map of the return, rotate and subtract execution unit
//
// Functional notes
// - return: pop stack into pc, two cycles
// - rotate right through carry, one cycle
// - target bit picks working register or file
// - register minus working minus borrow, flags updated
// - immediate minus working minus borrow into working
// - working register into selected s-page register
// - selected s-page register into working register
// - register minus working register, flags updated
package rrs_pkg;

  // ----------------------------------------------------------------
  // widths and sizes
  // ----------------------------------------------------------------
  localparam int FILE_DEPTH    = 128;
  localparam int SFR_COUNT     = 22;
  localparam int RET_CYCLES    = 2;

  // ----------------------------------------------------------------
  // register port map (byte addresses of the plain register port)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FILE_LAST = 8'h7F;
  localparam logic [7:0] ADDR_WORK      = 8'h80;
  localparam logic [7:0] ADDR_STATUS    = 8'h81;
  localparam logic [7:0] ADDR_PC_LO     = 8'h82;
  localparam logic [7:0] ADDR_PC_HI     = 8'h83;
  localparam logic [7:0] ADDR_SP        = 8'h84;
  localparam logic [7:0] ADDR_SFR_BASE  = 8'hA0;
  localparam logic [7:0] ADDR_SFR_LAST  = 8'hB5;

  // ----------------------------------------------------------------
  // status field positions and reset values
  // ----------------------------------------------------------------
  localparam int STAT_CARRY_BIT  = 0;
  localparam int STAT_NIBBLE_BIT = 1;
  localparam int STAT_ZERO_BIT   = 2;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] SFR_RESET  = 8'h00;
  localparam logic       FLAG_RESET = 1'b0;

  // ----------------------------------------------------------------
  // opcodes and sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    OP_CALL_EXIT   = 3'h0,
    OP_ROT_RIGHT   = 3'h1,
    OP_SUB_BOR_REG = 3'h2,
    OP_SUB_BOR_IMM = 3'h3,
    OP_SFR_WRITE   = 3'h4,
    OP_SFR_READ    = 3'h5,
    OP_REG_MINUS   = 3'h6
  } rrs_op_t;

  typedef enum logic [1:0] {
    ST_RUN      = 2'b01,
    ST_RET_WAIT = 2'b10
  } rrs_state_t;

endpackage

// ===== rrs_sub_unit.sv
// eight-bit subtractor: a + ~b + cin with borrow-inverse flags
`timescale 1ns/1ps
module rrs_sub_unit (
  a,
  b,
  cin,
  diff,
  carry_out,
  nibble_out,
  zero_out
);
  input  wire logic [7:0] a;
  input  wire logic [7:0] b;
  input  wire logic       cin;
  output logic      [7:0] diff;
  output logic            carry_out;
  output logic            nibble_out;
  output logic            zero_out;

  logic [8:0] full_sum;
  logic [4:0] low_sum;

  // carry out of each adder stage is the inverse of a borrow
  always_comb begin
    full_sum   = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
    low_sum    = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
    diff       = full_sum[7:0];
    carry_out  = full_sum[8];
    nibble_out = low_sum[4];
    zero_out   = (full_sum[7:0] == 8'h00);
  end
endmodule

// ===== tb.sv
// self-checking bench for the return, rotate and subtract execution unit
`timescale 1ns/1ps
module tb;
  import rrs_pkg::*;
  logic        clk, rst_n, op_valid, op_to_reg, op_ready, call_push, reg_wr, reg_rd;
  logic        carry_q, nibble_q, zero_q, c, to;
  rrs_op_t     op_code, oc;
  logic [6:0]  op_reg_addr;
  logic [4:0]  op_sfr_idx;
  logic [7:0]  op_imm, reg_addr, reg_wdata, reg_rdata, work_q, a, w;
  logic [10:0] call_push_addr, pc_q, e;
  int          n_errors, total_checks;

  rrs_exec_unit #(.PC_WIDTH(11), .STACK_DEPTH(8)) dut_u (.clk(clk), .rst_n(rst_n),
    .op_valid(op_valid), .op_code(op_code), .op_reg_addr(op_reg_addr), .op_to_reg(op_to_reg),
    .op_imm(op_imm), .op_sfr_idx(op_sfr_idx), .op_ready(op_ready), .call_push(call_push),
    .call_push_addr(call_push_addr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .work_q(work_q),
    .carry_q(carry_q), .nibble_q(nibble_q), .zero_q(zero_q), .pc_q(pc_q));

  always #25 clk = ~clk;

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [10:0] exp, input logic [10:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, input logic [7:0] exp, input string nm);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk(nm, {3'h0, exp}, {3'h0, reg_rdata});
  endtask
  task automatic op(input rrs_op_t cd, input logic [6:0] ad, input logic t,
                    input logic [7:0] i, input logic [4:0] s);
    @(posedge clk);
    op_valid    <= 1'b1;
    op_code     <= cd;
    op_reg_addr <= ad;
    op_to_reg   <= t;
    op_imm      <= i;
    op_sfr_idx  <= s;
    @(posedge clk);
    op_valid <= 1'b0;
    #1;
  endtask
  task automatic push(input logic [10:0] ad);
    @(posedge clk);
    call_push      <= 1'b1;
    call_push_addr <= ad;
    @(posedge clk);
    call_push <= 1'b0;
  endtask
  // reference subtract: {zero, nibble carry, carry, result}
  function automatic logic [10:0] ref_sub(input logic [7:0] x, y, input logic ci);
    logic [8:0] s;
    logic [4:0] n;
    s = {1'b0, x} + {1'b0, ~y} + {8'h00, ci};
    n = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, ci};
    return {s[7:0] == 8'h00, n[4], s[8], s[7:0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {clk, rst_n, op_valid, op_to_reg, call_push, reg_wr, reg_rd} = '0;
    op_code = OP_CALL_EXIT;
    {op_reg_addr, op_sfr_idx, op_imm, reg_addr, reg_wdata, call_push_addr} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(ADDR_WORK, 8'h00, "reset work");
    rd(ADDR_STATUS, 8'h00, "reset status");
    rd(8'h90, 8'h00, "unmapped");
    $display("test reset done");
    // both borrow signs, both carry-ins, both targets for register minus, all three subtracts
    for (int k = 0; k < 12; k++) begin
      oc = (k < 4) ? OP_SUB_BOR_REG : (k < 8) ? OP_SUB_BOR_IMM : OP_REG_MINUS;
      a  = k[1] ? 8'h06 : 8'h05;
      w  = k[1] ? 8'h05 : 8'h06;
      c  = k[0];
      to = (oc != OP_SUB_BOR_IMM) && (oc == OP_SUB_BOR_REG || k[0]);
      e  = ref_sub(a, w, (oc == OP_REG_MINUS) ? 1'b1 : c);
      wr(8'h10, a);
      wr(ADDR_WORK, w);
      wr(ADDR_STATUS, {7'h00, c});
      op(oc, 7'h10, to, a, 5'h00);
      rd(to ? 8'h10 : ADDR_WORK, e[7:0], "sub result");
      rd(to ? ADDR_WORK : 8'h10, to ? w : a, "sub untouched");
      rd(ADDR_STATUS, {5'h00, e[10:8]}, "sub status");
    end
    // low nibble borrows while the byte does not, so nibble and carry flags part ways
    wr(8'h10, 8'h10);
    wr(ADDR_WORK, 8'h01);
    wr(ADDR_STATUS, 8'h01);
    op(OP_REG_MINUS, 7'h10, 1'b0, 8'h00, 5'h00);
    rd(ADDR_WORK, 8'h0F, "nibble minus result");
    rd(ADDR_STATUS, 8'h01, "nibble minus status");
    op(OP_SUB_BOR_IMM, 7'h00, 1'b0, 8'h20, 5'h00);
    rd(ADDR_WORK, 8'h11, "nibble imm result");
    rd(ADDR_STATUS, 8'h01, "nibble imm status");
    $display("test subtract done");
    wr(8'h20, 8'hA5);
    wr(ADDR_STATUS, 8'h06);
    op(OP_ROT_RIGHT, 7'h20, 1'b1, 8'h00, 5'h00);
    rd(8'h20, 8'h52, "rotate file");
    rd(ADDR_STATUS, 8'h07, "rotate status");
    op(OP_ROT_RIGHT, 7'h20, 1'b0, 8'h00, 5'h00);
    rd(ADDR_WORK, 8'hA9, "rotate work");
    rd(8'h20, 8'h52, "rotate source");
    rd(ADDR_STATUS, 8'h06, "rotate status");
    $display("test rotate done");
    wr(ADDR_WORK, 8'hAA);
    wr(ADDR_STATUS, 8'h05);
    op(OP_SFR_WRITE, 7'h00, 1'b0, 8'h00, 5'd21);
    wr(ADDR_WORK, 8'h3C);
    op(OP_SFR_WRITE, 7'h00, 1'b0, 8'h00, 5'd0);
    rd(ADDR_SFR_LAST, 8'hAA, "sfr last");
    rd(ADDR_SFR_BASE, 8'h3C, "sfr first");
    op(OP_SFR_READ, 7'h00, 1'b0, 8'h00, 5'd21);
    rd(ADDR_WORK, 8'hAA, "sfr read");
    op(OP_SFR_READ, 7'h00, 1'b0, 8'h00, 5'd22);
    rd(ADDR_WORK, 8'h00, "sfr beyond");
    rd(ADDR_STATUS, 8'h05, "sfr status");
    $display("test s-page done");
    push(11'h123);
    push(11'h045);
    wr(ADDR_STATUS, 8'h03);
    for (int j = 0; j < 2; j++) begin
      op(OP_CALL_EXIT, 7'h00, 1'b0, 8'h00, 5'h00);
      chk("ready low", 11'h000, {10'h000, op_ready});
      chk("pc", j ? 11'h123 : 11'h045, pc_q);
      @(posedge clk);
      #1;
      chk("ready high", 11'h001, {10'h000, op_ready});
    end
    rd(ADDR_SP, 8'h00, "stack level");
    rd(ADDR_PC_LO, 8'h23, "pc low byte");
    rd(ADDR_PC_HI, 8'h01, "pc high bits");
    rd(ADDR_STATUS, 8'h03, "return status");
    $display("test return done");
    give_verdict();
  end

  // hang guard, about fifteen times the expected run
  initial begin
    #200000;
    n_errors++;
    give_verdict();
  end
endmodule

bind rrs_exec_unit rrs_exec_monitor #(.PC_WIDTH(PC_WIDTH), .STACK_DEPTH(STACK_DEPTH)) mon_u (
  .clk(clk), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code), .op_reg_addr(op_reg_addr),
  .op_to_reg(op_to_reg), .op_imm(op_imm), .op_sfr_idx(op_sfr_idx), .op_ready(op_ready),
  .call_push(call_push), .call_push_addr(call_push_addr), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .work_q(work_q), .carry_q(carry_q), .nibble_q(nibble_q), .zero_q(zero_q), .pc_q(pc_q));
